// File: rtl/sram_host_pkg.sv
// Package: constants, timing and types for the 1k x 1 static RAM host controller
package sram_host_pkg;

   localparam int ADDR_W = 10;
   localparam int WORDS = 1024;
   localparam int CLK_PERIOD_NS = 4;

   // Speed grade selection codes
   localparam logic [1:0] GRADE_FAST = 2'h0;
   localparam logic [1:0] GRADE_MID = 2'h1;
   localparam logic [1:0] GRADE_SLOW = 2'h2;

   // Address valid (cycle) minimum per grade, ns
   localparam int T_CYC_FAST_NS = 450;
   localparam int T_CYC_MID_NS = 650;
   localparam int T_CYC_SLOW_NS = 1000;
   // Address setup before write strobe per grade, ns
   localparam int T_AS_FAST_NS = 150;
   localparam int T_AS_MID_NS = 200;
   localparam int T_AS_SLOW_NS = 200;
   // Write pulse width per grade, ns
   localparam int T_WP_FAST_NS = 250;
   localparam int T_WP_MID_NS = 400;
   localparam int T_WP_SLOW_NS = 750;
   // Data setup before write end per grade, ns
   localparam int T_DS_FAST_NS = 300;
   localparam int T_DS_MID_NS = 450;
   localparam int T_DS_SLOW_NS = 800;
   // Hold of address and data after write end, ns
   localparam int T_HOLD_NS = 50;
   // Read access time from address per grade, ns
   localparam int T_ACC_FAST_NS = 450;
   localparam int T_ACC_MID_NS = 650;
   localparam int T_ACC_SLOW_NS = 1000;

   // Least times rounded up to cycles
   localparam int C_CYC_FAST = (T_CYC_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_CYC_MID = (T_CYC_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_CYC_SLOW = (T_CYC_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_AS_FAST = (T_AS_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_AS_MID = (T_AS_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_AS_SLOW = (T_AS_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_WP_FAST = (T_WP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_WP_MID = (T_WP_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_WP_SLOW = (T_WP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_DS_FAST = (T_DS_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_DS_MID = (T_DS_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_DS_SLOW = (T_DS_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_HOLD = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_ACC_FAST = (T_ACC_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_ACC_MID = (T_ACC_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_ACC_SLOW = (T_ACC_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Spare read cycles: two sync flops plus one for margin
   localparam int C_RD_SYNC = 3;

   localparam int CNT_W = 9;

   // Values after reset
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

   // Host request carrier, grade timing set and sequencer states
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic data;
   } host_req_t;

   typedef struct packed {
      logic [CNT_W-1:0] cycle;
      logic [CNT_W-1:0] setup;
      logic [CNT_W-1:0] pulse;
      logic [CNT_W-1:0] dsetup;
      logic [CNT_W-1:0] access;
   } timing_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RD = 6'h02,
      ST_WSETUP = 6'h04,
      ST_WPULSE = 6'h08,
      ST_WHOLD = 6'h10,
      ST_WREST = 6'h20
   } state_t;

endpackage

// File: rtl/sram_host.sv
// Host controller that runs read and write cycles on a 1k x 1 static RAM
//
// Function
// - The address is not latched, so the host holds it stable for the whole cycle.
// - Each address stays valid at least 450, 650 or 1000 ns by speed grade.
// - A single-memory system may hold the select low at all times.
// - On a read the select stays low until after the address has settled.
// - On a write the select goes low before the write strobe is asserted.
// - The write strobe returns to read state before an address change and stays a while.
// - Write data is valid at least 300 ns (fastest grade) before the strobe ends.
// - Write data is held at least 50 ns after the write pulse ends.
`timescale 1ns/1ns
module sram_host #(
   parameter logic [1:0] GRADE = sram_host_pkg::GRADE_FAST,
   parameter bit SELECT_TIED = 1'b0
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire sram_host_pkg::host_req_t REQ,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   output logic RD_DATA,
   output logic RD_VALID,
   output logic [sram_host_pkg::ADDR_W-1:0] WORD_ADDR,
   output logic SEL_N,
   output logic RW,
   output logic BIT_IN,
   input wire logic DATA_OUT
);

   // ----------------------------------------------------------------
   // Reset release and pin synchroniser
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic dout_meta_q;
   logic dout_q;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dout_meta_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         dout_meta_q <= DATA_OUT;
         dout_q <= dout_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Timing per grade
   // ----------------------------------------------------------------
   function automatic sram_host_pkg::timing_t grade_timing(input logic [1:0] g);
      sram_host_pkg::timing_t t;
      case (g)
         sram_host_pkg::GRADE_MID: begin
            t.cycle = 9'(sram_host_pkg::C_CYC_MID);
            t.setup = 9'(sram_host_pkg::C_AS_MID);
            t.pulse = 9'(sram_host_pkg::C_WP_MID);
            t.dsetup = 9'(sram_host_pkg::C_DS_MID);
            t.access = 9'(sram_host_pkg::C_ACC_MID);
         end
         sram_host_pkg::GRADE_SLOW: begin
            t.cycle = 9'(sram_host_pkg::C_CYC_SLOW);
            t.setup = 9'(sram_host_pkg::C_AS_SLOW);
            t.pulse = 9'(sram_host_pkg::C_WP_SLOW);
            t.dsetup = 9'(sram_host_pkg::C_DS_SLOW);
            t.access = 9'(sram_host_pkg::C_ACC_SLOW);
         end
         default: begin
            t.cycle = 9'(sram_host_pkg::C_CYC_FAST);
            t.setup = 9'(sram_host_pkg::C_AS_FAST);
            t.pulse = 9'(sram_host_pkg::C_WP_FAST);
            t.dsetup = 9'(sram_host_pkg::C_DS_FAST);
            t.access = 9'(sram_host_pkg::C_ACC_FAST);
         end
      endcase
      return t;
   endfunction

   localparam sram_host_pkg::timing_t TIM = grade_timing(GRADE);
   // Write pulse long enough for both pulse width and data setup
   localparam logic [8:0] WPULSE = (TIM.pulse > TIM.dsetup) ? TIM.pulse : TIM.dsetup;
   localparam logic [8:0] HOLD = 9'(sram_host_pkg::C_HOLD);
   // Cycles after the hold needed to fill the cycle time
   localparam int WUSED = int'(TIM.setup) + int'(WPULSE) + int'(HOLD);
   localparam logic [8:0] WREST = (int'(TIM.cycle) > WUSED) ?
      9'(int'(TIM.cycle) - WUSED) : 9'h001;
   // Read cycle covers access time plus the synchroniser, else data is sampled too early
   localparam int RNEED = int'(TIM.access) + sram_host_pkg::C_RD_SYNC;
   localparam logic [8:0] RCYC = (RNEED > int'(TIM.cycle)) ? 9'(RNEED) : TIM.cycle;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   sram_host_pkg::state_t state_q;
   logic [8:0] cnt_q;
   logic cnt_done;
   assign cnt_done = (cnt_q == 9'h001);

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sram_host_pkg::ST_IDLE;
         cnt_q <= 9'h000;
      end else begin
         case (state_q)
            sram_host_pkg::ST_IDLE: begin
               if (REQ_VALID) begin
                  if (REQ.write) begin
                     state_q <= sram_host_pkg::ST_WSETUP;
                     cnt_q <= TIM.setup;
                  end else begin
                     state_q <= sram_host_pkg::ST_RD;
                     cnt_q <= RCYC;
                  end
               end
            end
            sram_host_pkg::ST_RD: begin
               cnt_q <= cnt_q - 9'h001;
               if (cnt_done) begin
                  state_q <= sram_host_pkg::ST_IDLE;
               end
            end
            sram_host_pkg::ST_WSETUP: begin
               cnt_q <= cnt_q - 9'h001;
               if (cnt_done) begin
                  state_q <= sram_host_pkg::ST_WPULSE;
                  cnt_q <= WPULSE;
               end
            end
            sram_host_pkg::ST_WPULSE: begin
               cnt_q <= cnt_q - 9'h001;
               if (cnt_done) begin
                  state_q <= sram_host_pkg::ST_WHOLD;
                  cnt_q <= HOLD;
               end
            end
            sram_host_pkg::ST_WHOLD: begin
               cnt_q <= cnt_q - 9'h001;
               if (cnt_done) begin
                  state_q <= sram_host_pkg::ST_WREST;
                  cnt_q <= WREST;
               end
            end
            sram_host_pkg::ST_WREST: begin
               cnt_q <= cnt_q - 9'h001;
               if (cnt_done) begin
                  state_q <= sram_host_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= sram_host_pkg::ST_IDLE;
               cnt_q <= 9'h000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Memory pins
   // ----------------------------------------------------------------
   logic start;
   assign start = (state_q == sram_host_pkg::ST_IDLE) && REQ_VALID;

   // Address and data change only at cycle start and stay put till the next
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         WORD_ADDR <= sram_host_pkg::ADDR_RST;
         BIT_IN <= 1'b0;
      end else if (start) begin
         WORD_ADDR <= REQ.addr;
         if (REQ.write) begin
            BIT_IN <= REQ.data;
         end
      end
   end

   // Select low for the whole cycle, raised in idle unless tied low
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         SEL_N <= 1'b1;
      end else if (start || SELECT_TIED) begin
         SEL_N <= 1'b0;
      end else if (state_q == sram_host_pkg::ST_RD && cnt_done) begin
         SEL_N <= 1'b1;
      end else if (state_q == sram_host_pkg::ST_WREST && cnt_done) begin
         SEL_N <= 1'b1;
      end
   end

   // Strobe low only inside the pulse, high again before address moves
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         RW <= 1'b1;
      end else if (state_q == sram_host_pkg::ST_WSETUP && cnt_done) begin
         RW <= 1'b0;
      end else if (state_q == sram_host_pkg::ST_WPULSE && cnt_done) begin
         RW <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Host answer
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         REQ_READY <= 1'b0;
      end else begin
         REQ_READY <= (state_q == sram_host_pkg::ST_IDLE) && !REQ_VALID;
      end
   end

   // Data sampled at end of read cycle, after access time plus sync delay
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         RD_DATA <= 1'b0;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= 1'b0;
         if (state_q == sram_host_pkg::ST_RD && cnt_done) begin
            RD_DATA <= dout_q;
            RD_VALID <= 1'b1;
         end
      end
   end

endmodule

// File: verif/sram_host_chk.sv
// Checker for the memory pin timing of the static RAM host controller
`timescale 1ns/1ns
module sram_host_chk #(
   parameter logic [1:0] GRADE = sram_host_pkg::GRADE_FAST,
   parameter bit SELECT_TIED = 1'b0
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic RD_VALID,
   input wire logic [sram_host_pkg::ADDR_W-1:0] WORD_ADDR,
   input wire logic SEL_N,
   input wire logic RW,
   input wire logic BIT_IN
);
   localparam int CYC = GRADE == 2'h0 ? sram_host_pkg::C_CYC_FAST :
      GRADE == 2'h1 ? sram_host_pkg::C_CYC_MID : sram_host_pkg::C_CYC_SLOW;
   localparam int DS = GRADE == 2'h0 ? sram_host_pkg::C_DS_FAST :
      GRADE == 2'h1 ? sram_host_pkg::C_DS_MID : sram_host_pkg::C_DS_SLOW;
   localparam int HOLD = sram_host_pkg::C_HOLD;
   int addr_age_q;
   int bit_age_q;
   int rw_hi_q;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // Cycles since address or data last moved, and since the strobe was last low
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         addr_age_q <= 1000;
         bit_age_q <= 1000;
         rw_hi_q <= 1000;
      end else begin
         addr_age_q <= $changed(WORD_ADDR) ? 0 : addr_age_q + (addr_age_q < 1000);
         bit_age_q <= $changed(BIT_IN) ? 0 : bit_age_q + (bit_age_q < 1000);
         rw_hi_q <= !RW ? 0 : rw_hi_q + (rw_hi_q < 1000);
      end
   end
   chk_addr_held: assert property (!RW |-> !SEL_N && $stable(WORD_ADDR))
      else $error("address or select moved in write");
   chk_addr_valid: assert property ($changed(WORD_ADDR) |-> addr_age_q >= CYC - 1)
      else $error("address valid time too short");
   chk_sel_past_addr: assert property ($rose(SEL_N) |-> $stable(WORD_ADDR))
      else $error("address moved as select released");
   chk_sel_first: assert property ($fell(RW) |-> !SEL_N && !$past(SEL_N))
      else $error("write strobe before select");
   chk_rw_idle: assert property ($changed(WORD_ADDR) |-> RW && rw_hi_q >= HOLD - 1)
      else $error("address moved near write strobe");
   chk_data_setup: assert property ($rose(RW) |-> bit_age_q >= DS - 1)
      else $error("write data setup too short");
   chk_data_hold: assert property ($changed(BIT_IN) |-> RW && rw_hi_q >= HOLD - 1)
      else $error("write data hold too short");
   chk_answer_end: assert property (RD_VALID |-> ($rose(SEL_N) || SELECT_TIED) &&
      rw_hi_q >= CYC - 1 && addr_age_q >= CYC - 1)
      else $error("read answer outside read cycle end");
   cov_write: cover property ($fell(RW));
   cov_read: cover property (RD_VALID);
   cov_b2b: cover property ($rose(SEL_N) ##[1:4] $fell(SEL_N));
endmodule
bind sram_host sram_host_chk #(.GRADE(GRADE), .SELECT_TIED(SELECT_TIED)) u_chk (
   .REF_CLK(REF_CLK), .RESETN(RESETN),
   .RD_VALID(RD_VALID), .WORD_ADDR(WORD_ADDR), .SEL_N(SEL_N), .RW(RW), .BIT_IN(BIT_IN));

// File: verif/sram_mem_model.sv
// Behavioural 1k x 1 static RAM on the controller's memory pins
`timescale 1ns/1ns
module sram_mem_model #(
   parameter int ACC = sram_host_pkg::C_ACC_FAST - 1
) (
   input wire logic clk,
   input wire logic sel_n,
   input wire logic rw,
   input wire logic [sram_host_pkg::ADDR_W-1:0] word_addr,
   input wire logic bit_in,
   output logic dq
);
   logic mem [sram_host_pkg::WORDS];
   logic last_q = 1'b0;
   logic [sram_host_pkg::ADDR_W-1:0] addr_q;
   int age_q;
   logic drive;
   // Slow access: counts from one edge after the last address move or select assertion
   always_ff @(posedge clk) begin
      addr_q <= word_addr;
      last_q <= dq;
      if (sel_n || word_addr != addr_q) begin
         age_q <= 0;
      end else if (age_q < ACC) begin
         age_q <= age_q + 1;
      end
   end
   always_ff @(posedge clk) begin
      if (!sel_n && !rw) begin
         mem[word_addr] <= bit_in;
      end
   end
   assign drive = !sel_n && rw && age_q >= ACC;
   // Released output toggles so stale data never passes for a read
   assign dq = drive ? mem[word_addr] : ~last_q;
endmodule

// File: verif/static_ram_1k_by_1_access_tb.sv
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ns
module static_ram_1k_by_1_access_tb;
   logic REF_CLK = 1'b0;
   logic RESETN = 1'b0;
   sram_host_pkg::host_req_t REQ = '0;
   logic REQ_VALID = 1'b0;
   logic RD_DATA, RD_VALID, SEL_N, RW, BIT_IN, DATA_OUT;
   logic REQ_READY;
   logic tied_rd_data, tied_rd_valid, tied_sel_n, tied_rw, tied_bit_in, tied_dout;
   logic [sram_host_pkg::ADDR_W-1:0] tied_addr;
   logic [sram_host_pkg::ADDR_W-1:0] WORD_ADDR;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   always #2 REF_CLK = ~REF_CLK;
   sram_host dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .REQ(REQ), .REQ_VALID(REQ_VALID),
      .REQ_READY(REQ_READY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .WORD_ADDR(WORD_ADDR),
      .SEL_N(SEL_N), .RW(RW), .BIT_IN(BIT_IN), .DATA_OUT(DATA_OUT));
   sram_mem_model mem (.clk(REF_CLK), .sel_n(SEL_N), .rw(RW), .word_addr(WORD_ADDR),
      .bit_in(BIT_IN), .dq(DATA_OUT));
   // Second controller with the select held low, on its own memory
   sram_host #(.SELECT_TIED(1'b1)) dut_tied (.REF_CLK(REF_CLK), .RESETN(RESETN), .REQ(REQ),
      .REQ_VALID(REQ_VALID), .REQ_READY(), .RD_DATA(tied_rd_data), .RD_VALID(tied_rd_valid),
      .WORD_ADDR(tied_addr), .SEL_N(tied_sel_n), .RW(tied_rw), .BIT_IN(tied_bit_in),
      .DATA_OUT(tied_dout));
   sram_mem_model mem_tied (.clk(REF_CLK), .sel_n(tied_sel_n), .rw(tied_rw),
      .word_addr(tied_addr), .bit_in(tied_bit_in), .dq(tied_dout));
   task automatic end_sim;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic tick;
      @(posedge REF_CLK);
      #1;
   endtask
   // One request, held until the select shows it taken, then run to its end
   task automatic op(input logic w, input logic [9:0] a, input logic d, output logic q);
      int n;
      tick();
      cmp_bit(REQ_READY, 1'b1, "ready when idle");
      REQ = '{write: w, addr: a, data: d};
      REQ_VALID = 1'b1;
      n = 0;
      do begin
         tick();
         n++;
      end while (SEL_N !== 1'b0 && n < 50);
      REQ_VALID = 1'b0;
      cmp_bit(REQ_READY, 1'b0, "ready while busy");
      do begin
         tick();
         n++;
      end while ((w ? SEL_N !== 1'b1 : RD_VALID !== 1'b1) && n < 400);
      q = RD_DATA;
      cmp_bit(n < 400, 1'b1, "cycle did not end");
      if (!w) begin
         cmp_bit(tied_rd_valid, 1'b1, "tied select read answer");
         cmp_bit(tied_rd_data, RD_DATA, "tied select read data");
      end
      cmp_bit(tied_sel_n, 1'b0, "tied select raised");
   endtask
   // Mid-run reset: pins go idle at once and the memory keeps its contents
   task automatic t_reset;
      logic q;
      tick();
      RESETN = 1'b0;
      tick();
      cmp_bit(SEL_N, 1'b1, "select in reset");
      cmp_bit(RW, 1'b1, "strobe in reset");
      cmp_bit(RD_VALID, 1'b0, "answer in reset");
      repeat (4) tick();
      RESETN = 1'b1;
      repeat (3) tick();
      op(1'b0, 10'h200, 1'b0, q);
      cmp_bit(q, 1'b1, "data kept over reset");
   endtask
   task automatic t_corners;
      logic q;
      for (int i = 0; i < 2; i++) begin
         op(1'b1, 10'h000, i[0], q);
         op(1'b1, 10'h3FF, !i[0], q);
         op(1'b0, 10'h000, 1'b0, q);
         cmp_bit(q, i[0], "lowest address");
         op(1'b0, 10'h3FF, 1'b0, q);
         cmp_bit(q, !i[0], "highest address");
      end
   endtask
   task automatic t_reread;
      logic q;
      op(1'b1, 10'h155, 1'b1, q);
      op(1'b0, 10'h155, 1'b0, q);
      cmp_bit(q, 1'b1, "first read");
      op(1'b0, 10'h155, 1'b0, q);
      cmp_bit(q, 1'b1, "second read");
      op(1'b1, 10'h155, 1'b0, q);
      op(1'b0, 10'h155, 1'b1, q);
      cmp_bit(q, 1'b0, "read after overwrite");
      op(1'b0, 10'h155, 1'b0, q);
      cmp_bit(q, 1'b0, "read data bit ignored");
   endtask
   task automatic t_walk;
      logic q;
      for (int i = 0; i < 10; i++) begin
         op(1'b1, 10'h001 << i, i[0], q);
      end
      for (int i = 0; i < 10; i++) begin
         op(1'b0, 10'h001 << i, 1'b0, q);
         cmp_bit(q, i[0], "walking address");
      end
      op(1'b0, 10'h000, 1'b0, q);
      cmp_bit(q, 1'b1, "address zero kept");
   endtask
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge REF_CLK);
      #1;
      RESETN = 1'b1;
      repeat (3) tick();
      cmp_bit(SEL_N, 1'b1, "idle select");
      cmp_bit(RW, 1'b1, "idle strobe");
      t_corners();
      t_reread();
      t_walk();
      t_reset();
      end_sim();
   end
endmodule
